// ### logic/actuator_feedback_control_reg.sv
/*
 Feedback loop configuration register with decoded fields for the loop.
 Assumes an upstream control-bus decoder on clk giving address, write strobe and data,
 and a calibration engine that may load the amplifier gain code.
*/
// Contract
// - Bit 7 picks rotating-mass or linear-resonant drive
// - Bits 6-4 set brake gain ratio, 7 disables
// - Reset gives brake code 3, type 0
// - Bits 3-2 select closed-loop gain
// - Loop gain resets to 1
// - Bits 1-0 amplifier gain, default 2, calibrated
`timescale 1ns/100ps
`include "fb_ctrl_regs.svh"
module actuator_feedback_control_reg (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	input wire fb_ctrl_pkg::byte_t reg_addr,
	input wire logic reg_wr,
	input wire fb_ctrl_pkg::byte_t reg_wdata,
	output fb_ctrl_pkg::byte_t reg_rdata,
	// Calibration result load
	input wire logic cal_gain_load,
	input wire fb_ctrl_pkg::gain2_t cal_gain,
	// Decoded fields to the loop
	output fb_ctrl_pkg::actuator_t actuator_type_select,
	output fb_ctrl_pkg::brake_code_t brake_gain_ratio,
	output logic brake_enable,
	output logic [4:0] brake_multiplier,
	output fb_ctrl_pkg::gain2_t loop_gain,
	output fb_ctrl_pkg::gain2_t backemf_amp_gain
);
	import fb_ctrl_pkg::*;

	// ****************
	// Register storage
	// ****************
	byte_t cfg_q, cfg_d;
	byte_t rdata_q, rdata_d;
	logic brake_en_q, brake_en_d;
	logic [4:0] mult_q, mult_d;
	logic sel;

	// Brake code to multiplier; code 7 yields zero
	function automatic logic [4:0] brake_mult(input brake_code_t c);
		case (c)
			3'h0: brake_mult = 5'h01;
			3'h1: brake_mult = 5'h02;
			3'h2: brake_mult = 5'h03;
			3'h3: brake_mult = 5'h04;
			3'h4: brake_mult = 5'h06;
			3'h5: brake_mult = 5'h08;
			3'h6: brake_mult = 5'h10;
			default: brake_mult = 5'h00;
		endcase
	endfunction

	// Address decode, shared by write and read paths
	assign sel = (reg_addr == `FEEDBACK_LOOP_CONFIG_ADDR);

	// ****************
	// Configuration word
	// ****************
	always_comb begin
		cfg_d = cfg_q;
		if (reg_wr && sel) begin
			cfg_d = reg_wdata;
		end
		// Calibration wins over a same-cycle host write of the gain bits,
		// so a racing host write cannot undo a fresh calibration result
		if (cal_gain_load) begin
			cfg_d[`BACKEMF_AMP_GAIN_HI:`BACKEMF_AMP_GAIN_LO] = cal_gain;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= `FB_CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ****************
	// Read data
	// ****************
	// Built from the next value so a read in the write cycle sees the new word;
	// one cycle of latency traded for a read port straight off a flop
	always_comb begin
		rdata_d = `RDATA_RST;
		if (sel) begin
			rdata_d = cfg_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= `RDATA_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ****************
	// Brake decode
	// ****************
	// Decoded from the next value so multiplier and ratio code change together
	always_comb begin
		brake_en_d = (cfg_d[`BRAKE_HI:`BRAKE_LO] != `BRAKE_OFF_CODE);
		mult_d = brake_mult(cfg_d[`BRAKE_HI:`BRAKE_LO]);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			brake_en_q <= `BRAKE_EN_RST;
			mult_q <= `BRAKE_MULT_RST;
		end else begin
			brake_en_q <= brake_en_d;
			mult_q <= mult_d;
		end
	end

	// ****************
	// Outputs
	// ****************
	assign reg_rdata = rdata_q;
	assign actuator_type_select = actuator_t'(cfg_q[`ACT_TYPE_BIT]);
	assign brake_gain_ratio = cfg_q[`BRAKE_HI:`BRAKE_LO];
	assign brake_enable = brake_en_q;
	assign brake_multiplier = mult_q;
	assign loop_gain = cfg_q[`LOOP_GAIN_HI:`LOOP_GAIN_LO];
	assign backemf_amp_gain = cfg_q[`BACKEMF_AMP_GAIN_HI:`BACKEMF_AMP_GAIN_LO];

	// ****************
	// Checks
	// ****************
	reset_value_a: assert property (@(posedge clk) !rst_n |=> cfg_q == 8'h36)
		else $error("bad reset value");
	loop_reset_a: assert property (@(posedge clk) !rst_n |=> loop_gain == 2'h1)
		else $error("loop gain reset wrong");
	write_store_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel && !cal_gain_load |=> cfg_q == $past(reg_wdata))
		else $error("write not stored");
	cal_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		cal_gain_load |=> backemf_amp_gain == $past(cal_gain))
		else $error("calibration gain not loaded");
	brake_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h7 |-> !brake_enable && brake_multiplier == 5'h00)
		else $error("brake not disabled");
	brake_max_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h6 |-> brake_multiplier == 5'h10)
		else $error("brake ratio 16 wrong");
	type_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel && !cal_gain_load |=> actuator_type_select == actuator_t'($past(reg_wdata[7])))
		else $error("actuator type wrong");
	gain_field_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel |=> loop_gain == $past(reg_wdata[3:2]))
		else $error("loop gain field wrong");
	readback_a: assert property (@(posedge clk) disable iff (!rst_n)
		sel && !reg_wr && !cal_gain_load |=> reg_rdata == $past(cfg_q))
		else $error("readback wrong");
	hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(reg_wr && sel) && !cal_gain_load |=> $stable(cfg_q))
		else $error("register changed unbidden");

	// ****************
	// Reset checks
	// ****************
	brake_reset_a: assert property (@(posedge clk) !rst_n |=> brake_enable && brake_multiplier == 5'h04)
		else $error("brake outputs reset wrong");
	type_reset_a: assert property (@(posedge clk) !rst_n |=> actuator_type_select == ACT_ROTATING)
		else $error("actuator type reset wrong");
	amp_reset_a: assert property (@(posedge clk) !rst_n |=> backemf_amp_gain == 2'h2)
		else $error("amplifier gain reset wrong");
	rdata_reset_a: assert property (@(posedge clk) !rst_n |=> reg_rdata == 8'h00)
		else $error("read data reset wrong");

	// ****************
	// Brake ratio checks
	// ****************
	brake_on_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio != 3'h7 |-> brake_enable)
		else $error("brake disabled wrongly");
	brake_x1_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h0 |-> brake_multiplier == 5'h01)
		else $error("brake ratio 1 wrong");
	brake_x2_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h1 |-> brake_multiplier == 5'h02)
		else $error("brake ratio 2 wrong");
	brake_x3_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h2 |-> brake_multiplier == 5'h03)
		else $error("brake ratio 3 wrong");
	brake_x4_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h3 |-> brake_multiplier == 5'h04)
		else $error("brake ratio 4 wrong");
	brake_x6_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h4 |-> brake_multiplier == 5'h06)
		else $error("brake ratio 6 wrong");
	brake_x8_a: assert property (@(posedge clk) disable iff (!rst_n)
		brake_gain_ratio == 3'h5 |-> brake_multiplier == 5'h08)
		else $error("brake ratio 8 wrong");
	brake_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel |=> brake_gain_ratio == $past(reg_wdata[6:4]))
		else $error("brake field wrong");

	// ****************
	// Access checks
	// ****************
	write_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel && !cal_gain_load |=> reg_rdata == $past(reg_wdata))
		else $error("write not seen on read port");
	unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		!sel |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	amp_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && sel && !cal_gain_load |=> backemf_amp_gain == $past(reg_wdata[1:0]))
		else $error("amplifier gain field wrong");
	cal_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
		cal_gain_load && reg_wr && sel |=>
		cfg_q[7:2] == $past(reg_wdata[7:2]) && backemf_amp_gain == $past(cal_gain))
		else $error("calibration and write merge wrong");
	cal_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		cal_gain_load && !(reg_wr && sel) |=> cfg_q[7:2] == $past(cfg_q[7:2]))
		else $error("calibration touched upper fields");
endmodule

// ### logic/fb_ctrl_regs.svh
/*
 Offsets, field positions and reset values of the feedback loop configuration register.
 Assumes inclusion by the design file only.
*/
`ifndef FB_CTRL_REGS_SVH
`define FB_CTRL_REGS_SVH
`define FEEDBACK_LOOP_CONFIG_ADDR 8'h1A
`define ACT_TYPE_BIT 7
`define BRAKE_HI 6
`define BRAKE_LO 4
`define LOOP_GAIN_HI 3
`define LOOP_GAIN_LO 2
`define BACKEMF_AMP_GAIN_HI 1
`define BACKEMF_AMP_GAIN_LO 0
`define ACT_TYPE_RST 1'h0
`define BRAKE_RST 3'h3
`define LOOP_GAIN_RST 2'h1
`define BACKEMF_AMP_GAIN_RST 2'h2
`define FB_CFG_RST 8'h36
`define BRAKE_OFF_CODE 3'h7
`define BRAKE_EN_RST 1'h1
`define BRAKE_MULT_RST 5'h04
`define RDATA_RST 8'h00
`endif

// ### logic/fb_ctrl_pkg.sv
/*
 Types for the feedback loop configuration register.
 Assumes fb_ctrl_regs.svh is on the include path.
*/
package fb_ctrl_pkg;
	typedef enum logic [0:0] {ACT_ROTATING = 1'h0, ACT_LINEAR = 1'h1} actuator_t;
	typedef logic [2:0] brake_code_t;
	typedef logic [1:0] gain2_t;
	typedef logic [7:0] byte_t;
endpackage

// ### verification/fb_host.sv
/*
 Host model that drives the register access port of the feedback configuration register.
 Assumes the bench calls its tasks only after reset is released.
*/
`timescale 1ns/100ps
module fb_host (
	// Bus
	input wire logic clk,
	output fb_ctrl_pkg::byte_t reg_addr,
	output logic reg_wr,
	output fb_ctrl_pkg::byte_t reg_wdata,
	input wire fb_ctrl_pkg::byte_t reg_rdata
);
	import fb_ctrl_pkg::*;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wr = 1'b1;
		reg_wdata = d;
		@(posedge clk) #1;
		reg_wr = 1'b0;
		// Released data inverted so stale values never look valid
		reg_wdata = ~d;
	endtask
	task automatic rd(input byte_t a, output byte_t d);
		@(posedge clk) #1 reg_addr = a;
		@(posedge clk) #1 d = reg_rdata;
	endtask
endmodule

// ### verification/actuator_feedback_control_reg_tb.sv
/*
 Bench for the feedback configuration register: reset values, field decode, readback.
 Assumes the host model drives the bus and the bench drives the calibration load.
*/
`timescale 1ns/100ps
module actuator_feedback_control_reg_tb;
	import fb_ctrl_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, cal_gain_load = 1'b0, reg_wr, be;
	gain2_t cal_gain = 2'h0, lg, ag;
	byte_t reg_addr, reg_wdata, reg_rdata, v, e;
	actuator_t t;
	brake_code_t b;
	logic [4:0] bm;
	int num_errors = 0, n_compared = 0;
	logic [4:0] mult [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
	always #4 clk = ~clk;
	fb_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	actuator_feedback_control_reg DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_gain_load(cal_gain_load), .cal_gain(cal_gain),
		.actuator_type_select(t), .brake_gain_ratio(b), .brake_enable(be), .brake_multiplier(bm),
		.loop_gain(lg), .backemf_amp_gain(ag));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		host.rd(8'h1A, v);
		check(v, 8'h36);
		check({2'h0, be, bm}, 8'h24);
		for (int i = 0; i < 8; i++) begin
			e = {i[0], i[2:0], i[1:0], ~i[1:0]};
			host.wr(8'h1A, e);
			check({t, b, lg, ag}, e);
			check({2'h0, be, bm}, {2'h0, i != 7, mult[i]});
			host.rd(8'h1A, v);
			check(v, e);
		end
		// Unmapped address must neither write nor read back
		host.wr(8'h20, 8'h00);
		host.rd(8'h20, v);
		check({t, b, lg, ag}, 8'hFC);
		check(v, 8'h00);
		// Calibration only after type, brake and gain are set
		@(posedge clk) #1 {cal_gain_load, cal_gain} = 3'h5;
		@(posedge clk) #1 cal_gain_load = 1'b0;
		host.rd(8'h1A, v);
		check(v, 8'hFD);
		// Calibration result landing in the cycle of a host write
		fork
			host.wr(8'h1A, 8'h00);
			begin
				@(posedge clk) #1 {cal_gain_load, cal_gain} = 3'h7;
				@(posedge clk) #1 cal_gain_load = 1'b0;
			end
		join
		check({t, b, lg, ag}, 8'h03);
		rst_n = 1'b0;
		@(posedge clk) #1 rst_n = 1'b1;
		check({t, b, lg, ag}, 8'h36);
		check({2'h0, be, bm}, 8'h24);
		check(reg_rdata, 8'h00);
		finish_test;
	end
	initial begin
		#20000 num_errors++;
		finish_test;
	end
endmodule
